//--- lds_far_side.sv
`timescale 1ns/1ps
`default_nettype none
// far side of the driver: trigger, chopper and enable lines plus analog
// and loop sources, launched just after an edge so they are sampled clean
module lds_far_side (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // levels requested by the bench
  input wire logic [2:0] want_lines,
  input wire logic [47:0] want_vals,
  // lines toward the driver
  output logic trigger_in,
  output logic hw_pulse_line,
  output logic hw_enable_line,
  output logic [15:0] analog_mv,
  output logic [15:0] loop_demand_ma,
  output logic [15:0] light_ext_mw
);
  //////////////////////////////////////////////////////////////////////////
  // lines held low in reset so the driver never sees a false trigger edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {trigger_in, hw_pulse_line, hw_enable_line} <= 3'h0;
      {analog_mv, loop_demand_ma, light_ext_mw} <= 48'h0;
    end else begin
      trigger_in <= want_lines[2];
      hw_pulse_line <= want_lines[1];
      hw_enable_line <= want_lines[0];
      analog_mv <= want_vals[47:32];
      loop_demand_ma <= want_vals[31:16];
      light_ext_mw <= want_vals[15:0];
    end
  end
endmodule : lds_far_side
`default_nettype wire

//--- lds_pkg.sv
`default_nettype none
package lds_pkg;
  // timebase: one control cycle is one microsecond
  localparam int CLK_PERIOD_NS = 5;
  localparam int US_NS = 1000;
  localparam int US_CYC = US_NS / CLK_PERIOD_NS;
  localparam logic [7:0] US_LAST = 8'(US_CYC - 1);
  // soft-start line accumulates in microamps per milliamp
  localparam logic [16:0] UA_PER_MA = 17'h003E8;
  localparam logic [15:0] MA_SAT = 16'hFFFF;
  // analog factor is in units of 1/1024 A/V, input in mV
  localparam int FACTOR_SHIFT = 10;
  localparam int CFG_N = 22;
  localparam int ADDR_W = 8;

  // register word index, byte address is four times the index
  typedef enum logic [4:0] {
    IX_CTRL, IX_STEADY_CUR, IX_CUR_HIGH, IX_CUR_LOW, IX_HIGH_TIME, IX_LOW_TIME,
    IX_RISE_TIME, IX_FALL_TIME, IX_PLS_HIGH, IX_PLS_LOW, IX_SLOPE, IX_FACTOR,
    IX_LIM_MAX, IX_LIM_MIN, IX_SS_START, IX_SS_RAMP, IX_HOST_CUR, IX_HOST_CMD,
    IX_LIGHT_STEADY, IX_LIGHT_HIGH, IX_LIGHT_LOW, IX_LIGHT_TIME, IX_STATUS
  } lds_idx_e;

  // control word field positions
  localparam int CTRL_CUR_LSB = 0;
  localparam int CTRL_PLS_LSB = 3;
  localparam int CTRL_EN_LSB = 5;
  localparam int CTRL_LGT_LSB = 7;
  localparam int CTRL_TRIG_BIT = 9;
  localparam int HOST_CHOP_BIT = 0;
  localparam int HOST_EN_BIT = 1;

  typedef enum logic [2:0] {CUR_GEN, CUR_STEADY, CUR_HOST, CUR_HW, CUR_LOOP} lds_cur_src_e;
  typedef enum logic [1:0] {PLS_OFF, PLS_GEN, PLS_HOST, PLS_HW} lds_pls_src_e;
  typedef enum logic [1:0] {EN_OFF, EN_ON, EN_HOST, EN_HW} lds_en_src_e;
  typedef enum logic [1:0] {LGT_STEADY, LGT_GEN, LGT_EXT, LGT_SPARE} lds_lgt_src_e;
  typedef enum logic [3:0] {
    GEN_RISE = 4'h1, GEN_HIGH = 4'h2, GEN_FALL = 4'h4, GEN_LOW = 4'h8
  } lds_gen_e;

  // reset values: steady source, mA, us, mA/us, uA/us, mW
  localparam logic [CFG_N-1:0][15:0] CFG_RESET = '{
    IX_CTRL: 16'h0001, IX_STEADY_CUR: 16'h0BB8, IX_CUR_HIGH: 16'h1388,
    IX_CUR_LOW: 16'h03E8, IX_HIGH_TIME: 16'h2710, IX_LOW_TIME: 16'h2710,
    IX_RISE_TIME: 16'h03E8, IX_FALL_TIME: 16'h03E8, IX_PLS_HIGH: 16'h03E8,
    IX_PLS_LOW: 16'h03E8, IX_SLOPE: 16'h000A, IX_FACTOR: 16'h0400,
    IX_LIM_MAX: 16'h3A98, IX_LIM_MIN: 16'h0000, IX_SS_START: 16'h2710,
    IX_SS_RAMP: 16'h000A, IX_HOST_CUR: 16'h0000, IX_HOST_CMD: 16'h0000,
    IX_LIGHT_STEADY: 16'h07D0, IX_LIGHT_HIGH: 16'h07D0, IX_LIGHT_LOW: 16'h03E8,
    IX_LIGHT_TIME: 16'h2710, default: 16'h0000};

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } lds_bus_s;

  typedef struct packed {
    logic [15:0] nominal_ma;
    logic chop_gate;
    logic out_enable;
    logic [15:0] light_sp_mw;
  } lds_out_s;

  typedef struct packed {
    logic [CFG_N-1:0][15:0] cfg;
    logic [31:0] rdata;
    logic [7:0] us_cnt;
    lds_cur_src_e cur_sel;
    lds_pls_src_e pls_sel;
    lds_en_src_e en_sel;
    lds_lgt_src_e lgt_sel;
    lds_gen_e gen_st;
    logic [15:0] gen_val;
    logic [15:0] gen_cnt;
    logic [23:0] ramp_acc;
    logic [15:0] slope_cnt;
    logic trig_prev;
    logic [15:0] pls_cnt;
    logic pls_gate;
    logic en_prev;
    logic [15:0] ss_ma;
    logic [16:0] ss_frac;
    logic [15:0] lgt_cnt;
    logic lgt_hi;
    lds_out_s out;
  } lds_state_s;

  localparam lds_state_s ST_RESET = '{cfg: CFG_RESET, cur_sel: CUR_STEADY, pls_sel: PLS_OFF,
    en_sel: EN_OFF, lgt_sel: LGT_STEADY, gen_st: GEN_LOW, pls_gate: 1'b1, default: '0};
endpackage : lds_pkg
`default_nettype wire

//--- lds_source_select.sv
// Function
// - internal generator ramps between high and low levels with set dwell and ramp times.
// - generated ramps never steeper than the configured edge-rate cap.
// - trigger rising edge restarts the current generator from its start.
// - steady source uses the configured steady current value.
// - host source takes nominal current from host-written value.
// - hardware source scales the analog input by the analog factor.
// - loop source uses the optical power loop output as nominal.
// - pulse source off leaves the gate open, output follows current stage.
// - pulse generator makes a gate from pulse high and low times.
// - chopper edges are applied directly, no ramp or slope shaping.
// - host pulse source sets the gate from host commands.
// - hardware pulse source sets the gate from the pulse control line.
// - enable off keeps the output disabled regardless of other settings.
// - enable on keeps the output enabled.
// - host enable is volatile and always starts disabled after reset.
// - hardware enable source follows the enable control line.
// - loop demand feeds the current stage as nominal value.
// - loop setpoint selectable from steady light, light generator or external data.
// - system maximum and minimum limits always clamp the nominal current.
// - under loop control with output enabled, a soft-start limit also applies.
// - edge-rate cap acts on generated nominal current, default 0.01 A/us.
// - analog factor converts input voltage to current, default 1 A/V.
`timescale 1ns/1ps
`default_nettype none
module lds_source_select (
  // clock, reset and clock enable
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // register port
  input wire lds_pkg::lds_bus_s bus_req,
  output var logic [31:0] bus_rdata,
  // hardware control lines
  input wire logic trigger_in,
  input wire logic hw_pulse_line,
  input wire logic hw_enable_line,
  // analog input and loop interfaces
  input wire logic [15:0] analog_mv,
  input wire logic [15:0] loop_demand_ma,
  input wire logic [15:0] light_ext_mw,
  // drive outputs
  output var lds_pkg::lds_out_s drive_out
);
  import lds_pkg::*;

  lds_state_s st;
  lds_state_s nxt;
  logic tick;
  logic en_now;
  logic trig_edge;

  //////////////////////////////////////////////////////////////////////////
  // decoding helpers

  // true when the address hits a writable configuration word
  function automatic logic is_cfg(input logic [ADDR_W-1:0] addr);
    return (addr[7] == 1'b0) && (addr[6:2] < 5'(CFG_N));
  endfunction : is_cfg

  // read mux: config words, then the status word, zero elsewhere
  function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] addr,
                                            input lds_state_s s);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (is_cfg(addr)) begin
      w = {16'h0000, s.cfg[addr[6:2]]};
    end else if (addr[7:2] == 6'(IX_STATUS)) begin
      w = {10'h000, s.gen_st, s.out.out_enable, s.out.chop_gate, s.out.nominal_ma};
    end
    return w;
  endfunction : read_word

  // dwell counters end one tick before reaching the limit count
  function automatic logic dwell_done(input logic [15:0] cnt, input logic [15:0] lim);
    return (17'(cnt) + 17'h00001) >= 17'(lim);
  endfunction : dwell_done

  // ramp length in clock cycles, used as the step divider
  function automatic logic [23:0] ramp_cycles(input logic [15:0] t_us);
    return 24'(t_us) * 24'(US_CYC);
  endfunction : ramp_cycles

  //////////////////////////////////////////////////////////////////////////
  // shared decodes

  assign tick = (st.us_cnt == US_LAST);
  assign trig_edge = st.cfg[IX_CTRL][CTRL_TRIG_BIT] && trigger_in && !st.trig_prev;

  // enable source mux; host bit is volatile so reset always lands disabled
  always_comb begin
    case (st.en_sel)
      EN_OFF: en_now = 1'b0;
      EN_ON: en_now = 1'b1;
      EN_HOST: en_now = st.cfg[IX_HOST_CMD][HOST_EN_BIT];
      EN_HW: en_now = hw_enable_line;
      default: en_now = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // next-state logic

  // everything holds while the clock enable is low
  always_comb begin
    logic [15:0] lo;
    logic [15:0] hi;
    logic [15:0] raw;
    logic [15:0] lim;
    logic [15:0] sc;
    logic [31:0] prod;
    logic [23:0] rcyc;
    logic [23:0] acc;
    logic [16:0] frac;
    logic can_step;
    lo = st.cfg[IX_CUR_LOW];
    hi = st.cfg[IX_CUR_HIGH];
    raw = 16'h0000;
    lim = 16'h0000;
    sc = tick ? 16'h0000 : st.slope_cnt;
    prod = 32'h0000_0000;
    rcyc = 24'h00_0000;
    acc = 24'h00_0000;
    frac = st.ss_frac;
    can_step = (st.cfg[IX_SLOPE] == 16'h0000) || (sc < st.cfg[IX_SLOPE]);
    nxt = st;
    if (clk_en) begin
      nxt.us_cnt = tick ? 8'h00 : st.us_cnt + 8'h01;
      nxt.slope_cnt = sc;
      nxt.trig_prev = trigger_in;

      // register port: writes land next edge, reads answer one cycle later
      if (bus_req.wr && is_cfg(bus_req.addr)) begin
        nxt.cfg[bus_req.addr[6:2]] = bus_req.wdata[15:0];
      end
      nxt.rdata = bus_req.rd ? read_word(bus_req.addr, st) : 32'h0000_0000;

      // selections switch only on the control-cycle boundary
      if (tick) begin
        nxt.cur_sel = lds_cur_src_e'(st.cfg[IX_CTRL][CTRL_CUR_LSB +: 3]);
        nxt.pls_sel = lds_pls_src_e'(st.cfg[IX_CTRL][CTRL_PLS_LSB +: 2]);
        nxt.en_sel = lds_en_src_e'(st.cfg[IX_CTRL][CTRL_EN_LSB +: 2]);
        nxt.lgt_sel = lds_lgt_src_e'(st.cfg[IX_CTRL][CTRL_LGT_LSB +: 2]);
      end

      // current waveform generator; ramps step 1 mA per clock at most,
      // so the steepest ramp is 0.2 A/us before the cap is applied
      case (st.gen_st)
        GEN_RISE: begin
          if (st.gen_val >= hi) begin
            nxt.gen_st = GEN_HIGH;
            nxt.gen_cnt = 16'h0000;
            nxt.ramp_acc = 24'h00_0000;
          end else if (can_step) begin
            rcyc = ramp_cycles(st.cfg[IX_RISE_TIME]);
            acc = st.ramp_acc + 24'(hi - lo);
            if (acc >= rcyc) begin
              nxt.gen_val = st.gen_val + 16'h0001;
              nxt.slope_cnt = sc + 16'h0001;
              acc = acc - rcyc;
            end
            nxt.ramp_acc = (acc > rcyc) ? rcyc : acc;
          end
        end
        GEN_HIGH: begin
          nxt.gen_val = hi;
          if (tick) begin
            if (dwell_done(st.gen_cnt, st.cfg[IX_HIGH_TIME])) begin
              nxt.gen_st = GEN_FALL;
              nxt.gen_cnt = 16'h0000;
            end else begin
              nxt.gen_cnt = st.gen_cnt + 16'h0001;
            end
          end
        end
        GEN_FALL: begin
          if (st.gen_val <= lo) begin
            nxt.gen_st = GEN_LOW;
            nxt.gen_cnt = 16'h0000;
            nxt.ramp_acc = 24'h00_0000;
          end else if (can_step) begin
            rcyc = ramp_cycles(st.cfg[IX_FALL_TIME]);
            acc = st.ramp_acc + 24'(hi - lo);
            if (acc >= rcyc) begin
              nxt.gen_val = st.gen_val - 16'h0001;
              nxt.slope_cnt = sc + 16'h0001;
              acc = acc - rcyc;
            end
            nxt.ramp_acc = (acc > rcyc) ? rcyc : acc;
          end
        end
        GEN_LOW: begin
          nxt.gen_val = lo;
          if (tick) begin
            if (dwell_done(st.gen_cnt, st.cfg[IX_LOW_TIME])) begin
              nxt.gen_st = GEN_RISE;
              nxt.gen_cnt = 16'h0000;
            end else begin
              nxt.gen_cnt = st.gen_cnt + 16'h0001;
            end
          end
        end
        default: begin
          nxt.gen_st = GEN_LOW;
        end
      endcase

      // trigger restart beats whatever the generator was doing
      if (trig_edge) begin
        nxt.gen_st = GEN_RISE;
        nxt.gen_val = lo;
        nxt.gen_cnt = 16'h0000;
        nxt.ramp_acc = 24'h00_0000;
      end

      // pulse gate generator, counts whole control cycles
      if (tick) begin
        if (dwell_done(st.pls_cnt, st.pls_gate ? st.cfg[IX_PLS_HIGH] : st.cfg[IX_PLS_LOW])) begin
          nxt.pls_gate = !st.pls_gate;
          nxt.pls_cnt = 16'h0000;
        end else begin
          nxt.pls_cnt = st.pls_cnt + 16'h0001;
        end
      end

      // light setpoint square generator for the loop
      if (tick) begin
        if (dwell_done(st.lgt_cnt, st.cfg[IX_LIGHT_TIME])) begin
          nxt.lgt_hi = !st.lgt_hi;
          nxt.lgt_cnt = 16'h0000;
        end else begin
          nxt.lgt_cnt = st.lgt_cnt + 16'h0001;
        end
      end

      // soft-start line: microamp remainder drains one mA per clock,
      // fast enough for any 16-bit ramp rate
      nxt.en_prev = en_now;
      if (frac >= UA_PER_MA) begin
        frac = frac - UA_PER_MA;
        if (st.ss_ma != MA_SAT) begin
          nxt.ss_ma = st.ss_ma + 16'h0001;
        end
      end
      if (tick) begin
        frac = frac + 17'(st.cfg[IX_SS_RAMP]);
      end
      nxt.ss_frac = frac;
      if (en_now && !st.en_prev) begin
        nxt.ss_ma = st.cfg[IX_SS_START];
        nxt.ss_frac = 17'h00000;
      end

      // nominal current source mux
      case (st.cur_sel)
        CUR_GEN: raw = st.gen_val;
        CUR_STEADY: raw = st.cfg[IX_STEADY_CUR];
        CUR_HOST: raw = st.cfg[IX_HOST_CUR];
        CUR_HW: begin
          prod = (32'(analog_mv) * 32'(st.cfg[IX_FACTOR])) >> FACTOR_SHIFT;
          raw = (|prod[31:16]) ? MA_SAT : prod[15:0];
        end
        CUR_LOOP: raw = loop_demand_ma;
        default: raw = 16'h0000;
      endcase

      // limits: soft-start only tightens the maximum, minimum is applied last
      lim = st.cfg[IX_LIM_MAX];
      if ((st.cur_sel == CUR_LOOP) && en_now && (st.ss_ma < lim)) begin
        lim = st.ss_ma;
      end
      if (raw > lim) begin
        raw = lim;
      end
      if (raw < st.cfg[IX_LIM_MIN]) begin
        raw = st.cfg[IX_LIM_MIN];
      end
      nxt.out.nominal_ma = raw;

      // chopper gate is a plain level, never ramped
      case (st.pls_sel)
        PLS_OFF: nxt.out.chop_gate = 1'b1;
        PLS_GEN: nxt.out.chop_gate = st.pls_gate;
        PLS_HOST: nxt.out.chop_gate = st.cfg[IX_HOST_CMD][HOST_CHOP_BIT];
        PLS_HW: nxt.out.chop_gate = hw_pulse_line;
        default: nxt.out.chop_gate = 1'b1;
      endcase
      nxt.out.out_enable = en_now;

      // loop setpoint select
      case (st.lgt_sel)
        LGT_GEN: nxt.out.light_sp_mw = st.lgt_hi ? st.cfg[IX_LIGHT_HIGH] : st.cfg[IX_LIGHT_LOW];
        LGT_EXT: nxt.out.light_sp_mw = light_ext_mw;
        default: nxt.out.light_sp_mw = st.cfg[IX_LIGHT_STEADY];
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // state register

  // whole state resets to constants, output disabled
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= ST_RESET;
    end else begin
      st <= nxt;
    end
  end

  assign bus_rdata = st.rdata;
  assign drive_out = st.out;

  //////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  a_enable_off_holds: assert property (
    clk_en && st.en_sel == EN_OFF |=> !drive_out.out_enable)
    else $error("output enabled while enable source is off");
  a_enable_on_holds: assert property (
    clk_en && st.en_sel == EN_ON |=> drive_out.out_enable)
    else $error("output disabled while enable source is on");
  a_reset_starts_off: assert property (
    $rose(reset_n) |-> !drive_out.out_enable && st.cfg[IX_HOST_CMD] == 16'h0000)
    else $error("output not disabled after reset");
  a_hw_enable_follows: assert property (
    clk_en && st.en_sel == EN_HW |=> drive_out.out_enable == $past(hw_enable_line))
    else $error("enable does not follow the hardware line");
  a_chop_off_open: assert property (
    clk_en && st.pls_sel == PLS_OFF |=> drive_out.chop_gate)
    else $error("gate closed while pulse stage is off");
  a_chop_line_direct: assert property (
    clk_en && st.pls_sel == PLS_HW |=> drive_out.chop_gate == $past(hw_pulse_line))
    else $error("gate does not follow the pulse line in one cycle");
  a_limits_clamp: assert property (
    clk_en && st.cfg[IX_LIM_MIN] <= st.cfg[IX_LIM_MAX]
    |=> drive_out.nominal_ma <= $past(st.cfg[IX_LIM_MAX])
        && drive_out.nominal_ma >= $past(st.cfg[IX_LIM_MIN]))
    else $error("nominal current outside system limits");
  a_steady_value: assert property (
    clk_en && st.cur_sel == CUR_STEADY && st.cfg[IX_LIM_MIN] <= st.cfg[IX_STEADY_CUR]
    && st.cfg[IX_STEADY_CUR] <= st.cfg[IX_LIM_MAX]
    |=> drive_out.nominal_ma == $past(st.cfg[IX_STEADY_CUR]))
    else $error("steady source value not passed through");
  a_trigger_restart: assert property (
    clk_en && trig_edge |=> st.gen_st == GEN_RISE && st.gen_val == $past(st.cfg[IX_CUR_LOW]))
    else $error("trigger did not restart the generator");
  a_softstart_cap: assert property (
    clk_en && st.cur_sel == CUR_LOOP && en_now && st.ss_ma >= st.cfg[IX_LIM_MIN]
    |=> drive_out.nominal_ma <= $past(st.ss_ma))
    else $error("nominal current above soft-start line");
  a_select_on_tick: assert property (
    clk_en && !tick |=> $stable(st.cur_sel) && $stable(st.pls_sel) && $stable(st.en_sel))
    else $error("source selection changed between control cycles");
  a_slope_stall: assert property (
    clk_en && !tick && !trig_edge && st.gen_st == GEN_RISE && st.cfg[IX_SLOPE] != 16'h0000
    && st.slope_cnt >= st.cfg[IX_SLOPE] |=> st.gen_val == $past(st.gen_val))
    else $error("ramp stepped past the edge-rate cap");

  c_trigger_seen: cover property (clk_en && trig_edge);
  c_loop_enable: cover property (clk_en && st.cur_sel == CUR_LOOP && en_now && !st.en_prev);
  c_gate_toggle: cover property (st.pls_sel == PLS_GEN ##1 $fell(drive_out.chop_gate));
  c_ramp_to_high: cover property (st.gen_st == GEN_RISE ##1 st.gen_st == GEN_HIGH);
endmodule : lds_source_select
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import lds_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  lds_bus_s bus_req = '0;
  logic [31:0] bus_rdata;
  logic [2:0] want_lines = 3'h0;
  logic [47:0] want_vals = 48'h0;
  logic trigger_in;
  logic hw_pulse_line;
  logic hw_enable_line;
  logic [15:0] analog_mv;
  logic [15:0] loop_demand_ma;
  logic [15:0] light_ext_mw;
  logic [15:0] base;
  lds_out_s drive_out;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n;

  //////////////////////////////////////////////////////////////////////////
  // 200 MHz clock
  always #2.5 clk = ~clk;

  lds_source_select u_dut (
    .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .trigger_in(trigger_in), .hw_pulse_line(hw_pulse_line), .hw_enable_line(hw_enable_line),
    .analog_mv(analog_mv), .loop_demand_ma(loop_demand_ma), .light_ext_mw(light_ext_mw),
    .drive_out(drive_out)
  );

  lds_far_side u_far (
    .clk(clk), .reset_n(reset_n), .want_lines(want_lines), .want_vals(want_vals),
    .trigger_in(trigger_in), .hw_pulse_line(hw_pulse_line), .hw_enable_line(hw_enable_line),
    .analog_mv(analog_mv), .loop_demand_ma(loop_demand_ma), .light_ext_mw(light_ext_mw)
  );

  //////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // settled sample point just after an edge
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : step

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    bus_req.addr <= a;
    bus_req.wdata <= {16'h0000, d};
    bus_req.wr <= 1'b1;
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1;
    chk(bus_rdata, exp);
  endtask : rd

  // selections land only at the next 1 us tick, so allow a full tick plus latency
  task automatic cfg(input logic [15:0] ctrl);
    wr(8'h00, ctrl);
    step(202);
  endtask : cfg

  task automatic run_len(input logic lvl, output int k);
    k = 0;
    while (drive_out.chop_gate === lvl && k < 5000) begin
      k++;
      step(1);
    end
  endtask : run_len

  task automatic wait_nom(input logic [15:0] v, output int k);
    k = 0;
    while (drive_out.nominal_ma !== v && k < 5000) begin
      k++;
      step(1);
    end
  endtask : wait_nom

  task automatic trig;
    want_lines <= 3'h4;
    step(1);
    want_lines <= 3'h0;
  endtask : trig

  //////////////////////////////////////////////////////////////////////////
  // hang guard, well above the expected run of about 10000 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failures++;
      final_report();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    step(2);
    chk(32'(drive_out.out_enable), 32'h0);
    chk(32'(drive_out.nominal_ma), 32'h00000BB8);
    chk(32'(drive_out.chop_gate), 32'h1);
    chk(32'(drive_out.light_sp_mw), 32'h000007D0);
    rd(8'h00, 32'h00000001);
    rd(8'h28, 32'h0000000A);
    rd(8'h2C, 32'h00000400);
    rd(8'h80, 32'h00000000);
    // status word: generator low, gate open, output off, steady nominal
    rd(8'h58, 32'h00210BB8);
    // limits hold in steady mode too
    wr(8'h04, 16'h4000);
    step(3);
    chk(32'(drive_out.nominal_ma), 32'h00003A98);
    wr(8'h34, 16'h0100);
    wr(8'h04, 16'h0050);
    step(3);
    chk(32'(drive_out.nominal_ma), 32'h00000100);
    wr(8'h34, 16'h0000);
    wr(8'h40, 16'h1234);
    cfg(16'h0002);
    chk(32'(drive_out.nominal_ma), 32'h00001234);
    want_vals <= {16'h07D0, 16'h0500, 16'h0123};
    cfg(16'h0003);
    chk(32'(drive_out.nominal_ma), 32'h000007D0);
    wr(8'h2C, 16'h0200);
    step(3);
    chk(32'(drive_out.nominal_ma), 32'h000003E8);
    cfg(16'h0004);
    chk(32'(drive_out.nominal_ma), 32'h00000500);
    // soft-start: flat line first, then 1 mA per tick
    wr(8'h38, 16'h0100);
    wr(8'h3C, 16'h0000);
    cfg(16'h0024);
    chk(32'(drive_out.nominal_ma), 32'h00000100);
    chk(32'(drive_out.out_enable), 32'h1);
    cfg(16'h0004);
    wr(8'h3C, 16'h03E8);
    cfg(16'h0024);
    base = drive_out.nominal_ma;
    step(2000);
    chk(32'(drive_out.nominal_ma - base), 32'h0000000A);
    // a low clock enable also stops the control cycle, so the new selection waits
    wr(8'h00, 16'h0101);
    clk_en <= 1'b0;
    step(400);
    chk(32'(drive_out.light_sp_mw), 32'h000007D0);
    @(posedge clk);
    clk_en <= 1'b1;
    step(202);
    chk(32'(drive_out.light_sp_mw), 32'h00000123);
    // light generator with one-tick half period: samples one tick apart sum high and low
    wr(8'h54, 16'h0001);
    cfg(16'h0081);
    base = drive_out.light_sp_mw;
    step(200);
    chk(32'(drive_out.light_sp_mw + base), 32'h00000BB8);
    // enable sources
    want_lines <= 3'h3;
    cfg(16'h0019);
    chk(32'(drive_out.out_enable), 32'h0);
    cfg(16'h0041);
    chk(32'(drive_out.out_enable), 32'h0);
    wr(8'h44, 16'h0002);
    step(3);
    chk(32'(drive_out.out_enable), 32'h1);
    wr(8'h44, 16'h0000);
    step(3);
    chk(32'(drive_out.out_enable), 32'h0);
    cfg(16'h0061);
    chk(32'(drive_out.out_enable), 32'h1);
    want_lines <= 3'h0;
    step(4);
    chk(32'(drive_out.out_enable), 32'h0);
    // chopper sources
    cfg(16'h0011);
    chk(32'(drive_out.chop_gate), 32'h0);
    wr(8'h44, 16'h0001);
    step(3);
    chk(32'(drive_out.chop_gate), 32'h1);
    cfg(16'h0019);
    chk(32'(drive_out.chop_gate), 32'h0);
    want_lines <= 3'h2;
    step(4);
    chk(32'(drive_out.chop_gate), 32'h1);
    wr(8'h20, 16'h0002);
    wr(8'h24, 16'h0003);
    cfg(16'h0009);
    run_len(1'b1, n);
    run_len(1'b0, n);
    run_len(1'b1, n);
    chk(32'(n), 32'h00000190);
    run_len(1'b0, n);
    chk(32'(n), 32'h00000258);
    chk(32'(drive_out.nominal_ma), 32'h00000050);
    // generator: 4 mA ramp under a 1 mA/us cap cannot finish inside 2 us
    wr(8'h0C, 16'h0100);
    wr(8'h08, 16'h0104);
    wr(8'h18, 16'h0001);
    wr(8'h1C, 16'h0001);
    wr(8'h10, 16'h0003);
    wr(8'h14, 16'h0003);
    wr(8'h28, 16'h0001);
    cfg(16'h0200);
    trig();
    wait_nom(16'h0104, n);
    chk(32'(n >= 400), 32'h1);
    chk(32'(drive_out.nominal_ma), 32'h00000104);
    wait_nom(16'h0100, n);
    chk(32'(drive_out.nominal_ma), 32'h00000100);
    trig();
    wait_nom(16'h0101, n);
    chk(32'(n < 300), 32'h1);
    final_report();
  end
endmodule : tb_top
`default_nettype wire
